// ==== dv/ped_pin_src.sv ====
`timescale 1ns/1ps
module ped_pin_src (
  // clock
  input wire logic aclk,
  // pins
  output logic [6:0] pins
);
  initial pins = 7'h00;

  // --------------------------------------------------------------
  // one high pulse; idle level low between pulses
  // --------------------------------------------------------------
  task automatic pulse(input int idx, input int w);
    @(posedge aclk);
    pins[idx] <= 1'b1;
    repeat (w) @(posedge aclk);
    pins[idx] <= 1'b0;
  endtask

  // --------------------------------------------------------------
  // switch chatter: one cycle per pattern bit, then a steady high
  // --------------------------------------------------------------
  task automatic bounce(input int idx, input logic [15:0] chatter,
                        input int w);
    @(posedge aclk);
    for (int k = 0; k < 16; k++) begin
      pins[idx] <= chatter[k];
      @(posedge aclk);
    end
    pins[idx] <= 1'b1;
    repeat (w) @(posedge aclk);
    pins[idx] <= 1'b0;
  endtask
endmodule

// ==== dv/ped_top_chk.sv ====
`timescale 1ns/1ps
module ped_top_chk
  import ped_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins and edges
  input wire logic clock_filter_pin_a,
  input wire logic analog_filter_pin_a,
  input wire logic halt_clock_mode,
  input wire logic [NUM_PINS-1:0] edge_detected
);
  logic [9:0] ana_q;
  logic pin_q;

  // cycles since the raw analog pin last moved, saturating
  always_ff @(posedge aclk) begin
    pin_q <= analog_filter_pin_a;
    if (!aresetn || pin_q != analog_filter_pin_a) begin
      ana_q <= 10'h000;
    end else if (ana_q != 10'h3ff) begin
      ana_q <= ana_q + 10'h001;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  bvalid_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  rvalid_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  read_cause_a: assert property (
    $rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
    else $error("read without request");
  read_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read not answered");
  write_answer_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
  pulse_width_a: assert property (
    edge_detected != 7'h00 |=>
    (edge_detected & $past(edge_detected)) == 7'h00)
    else $error("edge pulse too long");
  // the four filter samples behind an edge are pin values 4 to 7 back
  clk_filter_a: assert property (
    edge_detected[2] |->
    $past(clock_filter_pin_a, 4) == $past(clock_filter_pin_a, 5) &&
    $past(clock_filter_pin_a, 5) == $past(clock_filter_pin_a, 6) &&
    $past(clock_filter_pin_a, 6) == $past(clock_filter_pin_a, 7))
    else $error("unfiltered edge");
  halt_freeze_a: assert property (
    halt_clock_mode [*4] |-> edge_detected[4:1] == 4'h0)
    else $error("edge during halt");
  analog_delay_a: assert property (
    edge_detected[5] |-> ana_q >= 10'h3de)
    else $error("analog edge too early");

  cover property (edge_detected[5]);
  cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  cover property (halt_clock_mode && edge_detected[6]);
endmodule

bind ped_top ped_top_chk u_chk (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .clock_filter_pin_a,
  .analog_filter_pin_a, .halt_clock_mode, .edge_detected);

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  import ped_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0;
  logic [3:0] s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, halt_clock_mode = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd, rng;
  logic [6:0] pins, edge_detected;
  int mismatches = 0, checked = 0, cyc = 0, cnt[7], lat;
  always #5 aclk = ~aclk;

  ped_pin_src src (.aclk, .pins);
  ped_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .nonmaskable_edge_pin(pins[0]), .selectable_filter_pin(pins[1]),
    .clock_filter_pin_a(pins[2]), .clock_filter_pin_b(pins[3]),
    .clock_filter_pin_c(pins[4]), .analog_filter_pin_a(pins[5]),
    .analog_filter_pin_b(pins[6]), .halt_clock_mode, .edge_detected);

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  function automatic logic [31:0] nxt(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  function automatic int exp_pulses(input logic [1:0] m);
    return (m == EDGE_BOTH) ? 2 : (m == EDGE_NONE) ? 0 : 1;
  endfunction

  // negedge sampling: pulses are one cycle, so each is seen once
  always @(negedge aclk) begin
    for (int i = 0; i < 7; i++) if (edge_detected[i] === 1'b1) cnt[i]++;
  end

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // handshakes judged at negedge, where ready is settled for next edge
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    bit pa, pw, ta, tw;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    pa = 1;
    pw = 1;
    while (pa || pw) begin
      @(negedge aclk);
      ta = pa && s_axi_awready;
      tw = pw && s_axi_wready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      pa = pa && !ta;
      pw = pw && !tw;
    end
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [3:0] a);
    bit ta;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = s_axi_arready;
      @(posedge aclk);
    end while (!ta);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask

  task automatic pin_try(input int idx, input int w, input int exp);
    cnt = '{default: 0};
    src.pulse(idx, w);
    repeat ((idx == 0 || idx > 4) ? 1200 : 100) @(posedge aclk);
    chk(cnt.sum(), exp);
    chk(cnt[idx], exp);
  endtask

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    rng = 32'h50f0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      axi_rd(4'(4 * i));
      chk(rd, 32'h0);
    end
    chk(rsp, RESP_OKAY);
    for (int i = 0; i < 6; i++) begin
      rng = nxt(rng);
      axi_wr(4'(4 * (i % 3)), rng);
      axi_rd(4'(4 * (i % 3)));
      chk(rd, {24'h0, rng[7:0]});
    end
    axi_wr(ADDR_PIN_STATUS, 32'hff);
    chk(rsp, RESP_OKAY);
    axi_wr(4'h2, 32'h0);
    chk(rsp, RESP_SLVERR);
    axi_rd(4'h2);
    chk(rsp, RESP_SLVERR);
    chk(rd, 32'h0);
    axi_wr(ADDR_FILT_CLK_SEL, 32'h0);
    // lane 0 strobe low: the register must keep its value
    s_axi_wstrb <= 4'he;
    axi_wr(ADDR_FILT_CLK_SEL, 32'hff);
    s_axi_wstrb <= 4'hf;
    axi_rd(ADDR_FILT_CLK_SEL);
    chk(rd, 32'h0);
    axi_wr(ADDR_EDGE_SEL_B, 32'h16);
    for (int m = 0; m < 4; m++) begin
      axi_wr(ADDR_EDGE_SEL_A, {24'h0, 2'h1, 2'(m), 4'h5});
      pin_try(2, 20, exp_pulses(2'(m)));
    end
    pin_try(4, 20, 0);
    axi_wr(ADDR_EDGE_SEL_B, 32'h15);
    pin_try(4, 20, 1);
    pin_try(3, 3, 0);
    rng = nxt(rng);
    pin_try(3, 8 + int'(rng[4:0]), 1);
    fork
      src.pulse(3, 20);
      begin
        lat = 0;
        do begin
          @(negedge aclk);
          lat++;
        end while (edge_detected[3] !== 1'b1 && lat < 40);
      end
    join
    chk(lat >= 7 && lat <= 9, 1);
    repeat (40) @(posedge aclk);
    axi_wr(ADDR_FILT_CLK_SEL, 32'h3);
    pin_try(1, 20, 0);
    pin_try(1, 48, 1);
    // slow sampling: chatter never yields four equal samples
    rng = nxt(rng);
    cnt = '{default: 0};
    src.bounce(1, rng[15:0], 48);
    repeat (100) @(posedge aclk);
    chk(cnt[1], 1);
    axi_wr(ADDR_FILT_CLK_SEL, 32'h0);
    pin_try(1, 20, 1);
    // a clock-aligned four-cycle glitch passes the digital filter
    pin_try(1, 4, 1);
    pin_try(5, 500, 0);
    pin_try(5, 1100, 1);
    pin_try(0, 1100, 1);
    halt_clock_mode <= 1'b1;
    pin_try(2, 20, 0);
    pin_try(6, 1100, 1);
    halt_clock_mode <= 1'b0;
    // mid-run reset must clear every written register again
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      axi_rd(4'(4 * i));
      chk(rd, 32'h0);
    end
    complete_run();
  end
endmodule

// ==== logic/ped_filter.sv ====
`timescale 1ns/1ps
// one pin: level accepted after FILT_RUN equal samples taken on smp_en
module ped_filter
  import ped_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // sampling
  input wire logic smp_en,
  input wire logic din,
  // filtered level
  output logic level
);

  typedef struct packed {
    logic last;
    logic [1:0] cnt;
    logic level;
  } ped_filt_state_t;

  ped_filt_state_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (smp_en) begin
      s_d.last = din;
      if (din != s_q.last) begin
        s_d.cnt = '0;
      end else if (s_q.cnt != FILT_CNT_MAX) begin
        s_d.cnt = s_q.cnt + 2'h1;
      end else begin
        // fourth equal sample: the new level is taken
        s_d.level = din;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign level = s_q.level;

endmodule

// ==== logic/ped_pkg.sv ====
package ped_pkg;

  // ----------------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [3:0] ADDR_EDGE_SEL_A = 4'h0;
  localparam logic [3:0] ADDR_EDGE_SEL_B = 4'h4;
  localparam logic [3:0] ADDR_FILT_CLK_SEL = 4'h8;
  localparam logic [3:0] ADDR_PIN_STATUS = 4'hc;
  localparam logic [7:0] RESET_VAL = 8'h00;

  // ----------------------------------------------------------------------
  // edge field encoding: two bits per pin
  // ----------------------------------------------------------------------
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_NONE = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam int NUM_PINS = 7;
  localparam int PINS_A = 4;

  // ----------------------------------------------------------------------
  // digital filter
  // ----------------------------------------------------------------------
  localparam int FILT_RUN = 4;
  localparam logic [1:0] FILT_CNT_MAX = 2'(FILT_RUN - 2);
  localparam logic [2:0] SMP_DIV_MAX = 3'h7;
  localparam int SMP_SEL_W = 3;

  // ----------------------------------------------------------------------
  // analog delay model
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int ANALOG_DELAY_US = 10;
  localparam int ANALOG_CYCLES = ANALOG_DELAY_US * CLK_MHZ;
  localparam int ANALOG_CNT_W = 10;

  // ----------------------------------------------------------------------
  // axi responses
  // ----------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ==== logic/ped_top.sv ====
`timescale 1ns/1ps
module ped_top
  import ped_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins
  input wire logic nonmaskable_edge_pin,
  input wire logic selectable_filter_pin,
  input wire logic clock_filter_pin_a,
  input wire logic clock_filter_pin_b,
  input wire logic clock_filter_pin_c,
  input wire logic analog_filter_pin_a,
  input wire logic analog_filter_pin_b,
  // power mode
  input wire logic halt_clock_mode,
  // detected edges, one-cycle pulses
  output logic [NUM_PINS-1:0] edge_detected
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] edge_sel_a;
    logic [7:0] edge_sel_b;
    logic [7:0] filt_clk_sel;
    logic aw_got;
    logic [3:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [SMP_DIV_MAX:0] div;
    logic [NUM_PINS-1:0] level;
    logic [NUM_PINS-1:0] mute;
    logic [NUM_PINS-1:0] edge_out;
    logic [ANALOG_CNT_W-1:0] an_cnt0;
    logic [ANALOG_CNT_W-1:0] an_cnt1;
    logic [ANALOG_CNT_W-1:0] an_cnt2;
    logic [2:0] an_lvl;
  } ped_state_t;

  ped_state_t s_q, s_d;

  // ----------------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------------
  function automatic logic [1:0] field_of(input logic [15:0] sel,
                                          input int idx);
    field_of = sel[2*idx +: 2];
  endfunction

  function automatic logic is_valid_edge(input logic [1:0] mode,
                                         input logic old_l,
                                         input logic new_l);
    logic rise;
    logic fall;
    rise = !old_l && new_l;
    fall = old_l && !new_l;
    case (mode)
      EDGE_FALL: is_valid_edge = fall;
      EDGE_RISE: is_valid_edge = rise;
      EDGE_BOTH: is_valid_edge = rise || fall;
      default: is_valid_edge = 1'b0;
    endcase
  endfunction

  function automatic logic [7:0] merge(input logic [7:0] old_v,
                                       input logic [31:0] data,
                                       input logic strb);
    merge = strb ? data[7:0] : old_v;
  endfunction

  // analog delay: level follows only after input holds a full window
  function automatic logic [ANALOG_CNT_W-1:0] an_next(
      input logic [ANALOG_CNT_W-1:0] cnt, input logic in_l,
      input logic cur_l);
    if (in_l == cur_l) begin
      an_next = '0;
    end else begin
      an_next = cnt + ANALOG_CNT_W'(1);
    end
  endfunction

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic [NUM_PINS-1:0] pin_raw;
  logic [NUM_PINS-1:0] sync1_q;
  logic [NUM_PINS-1:0] sync2_q;

  assign pin_raw = {analog_filter_pin_b, analog_filter_pin_a,
                    clock_filter_pin_c, clock_filter_pin_b,
                    clock_filter_pin_a, selectable_filter_pin,
                    nonmaskable_edge_pin};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
    end
  end

  // ----------------------------------------------------------------------
  // sampling enables
  // ----------------------------------------------------------------------
  logic run_dig;
  logic smp_sel_en;
  logic [SMP_SEL_W-1:0] smp_code;

  // digital pins stop while the system clock is halted
  assign run_dig = !halt_clock_mode;
  assign smp_code = s_q.filt_clk_sel[SMP_SEL_W-1:0];

  // code n samples at aclk / 2**n; only the low three bits of filt_clk_sel form the code
  always_comb begin
    if (smp_code == '0) begin
      smp_sel_en = run_dig;
    end else begin
      smp_sel_en = run_dig && (s_q.div[smp_code-1 +: 1] == 1'b1) &&
                   ((s_q.div & ((8'h1 << (smp_code - 3'h1)) - 8'h1)) ==
                    8'h00);
    end
  end

  // ----------------------------------------------------------------------
  // digital filters
  // ----------------------------------------------------------------------
  logic [NUM_PINS-1:0] filt_lvl;

  ped_filter u_filt_sel (
    .aclk(aclk),
    .aresetn(aresetn),
    .smp_en(smp_sel_en),
    .din(sync2_q[1]),
    .level(filt_lvl[1])
  );

  genvar gi;
  generate
    for (gi = 2; gi < 5; gi++) begin : g_clk_filt
      ped_filter u_filt (
        .aclk(aclk),
        .aresetn(aresetn),
        .smp_en(run_dig),
        .din(sync2_q[gi]),
        .level(filt_lvl[gi])
      );
    end
  endgenerate

  assign filt_lvl[0] = s_q.an_lvl[0];
  assign filt_lvl[5] = s_q.an_lvl[1];
  assign filt_lvl[6] = s_q.an_lvl[2];

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic do_write;
  logic [15:0] sel_all;

  assign s_axi_awready = !s_q.aw_got && !s_q.bvalid;
  assign s_axi_wready = !s_q.w_got && !s_q.bvalid;
  assign s_axi_arready = !s_q.rvalid;
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs = s_axi_wvalid && s_axi_wready;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  assign do_write = s_q.aw_got && s_q.w_got;
  assign sel_all = {s_q.edge_sel_b, s_q.edge_sel_a};

  always_comb begin
    s_d = s_q;
    s_d.div = s_q.div + 8'h1;
    // write channel capture, either order
    if (aw_hs) begin
      s_d.aw_got = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (w_hs) begin
      s_d.w_got = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    s_d.mute = '0;
    if (do_write) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OKAY;
      // byte lane 0 only; bit writes are read-modify-write of a byte
      case (s_q.aw_addr)
        ADDR_EDGE_SEL_A: begin
          s_d.edge_sel_a = merge(s_q.edge_sel_a, s_q.w_data,
                                 s_q.w_strb[0]);
          s_d.mute[PINS_A-1:0] = '1;
        end
        ADDR_EDGE_SEL_B: begin
          s_d.edge_sel_b = merge(s_q.edge_sel_b, s_q.w_data,
                                 s_q.w_strb[0]);
          s_d.mute[NUM_PINS-1:PINS_A] = '1;
        end
        ADDR_FILT_CLK_SEL: begin
          s_d.filt_clk_sel = merge(s_q.filt_clk_sel, s_q.w_data,
                                   s_q.w_strb[0]);
        end
        ADDR_PIN_STATUS: begin
          s_d.bresp = RESP_OKAY;
        end
        default: begin
          s_d.bresp = RESP_SLVERR;
        end
      endcase
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    // read channel
    if (ar_hs) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = RESP_OKAY;
      s_d.rdata = '0;
      case (s_axi_araddr)
        ADDR_EDGE_SEL_A: s_d.rdata[7:0] = s_q.edge_sel_a;
        ADDR_EDGE_SEL_B: s_d.rdata[7:0] = s_q.edge_sel_b;
        ADDR_FILT_CLK_SEL: s_d.rdata[7:0] = s_q.filt_clk_sel;
        ADDR_PIN_STATUS: s_d.rdata[NUM_PINS-1:0] = s_q.level;
        default: s_d.rresp = RESP_SLVERR;
      endcase
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    // analog pins run even in halt modes
    s_d.an_cnt0 = an_next(s_q.an_cnt0, sync2_q[0], s_q.an_lvl[0]);
    s_d.an_cnt1 = an_next(s_q.an_cnt1, sync2_q[5], s_q.an_lvl[1]);
    s_d.an_cnt2 = an_next(s_q.an_cnt2, sync2_q[6], s_q.an_lvl[2]);
    if (s_q.an_cnt0 == ANALOG_CNT_W'(ANALOG_CYCLES - 1)) begin
      s_d.an_lvl[0] = sync2_q[0];
      s_d.an_cnt0 = '0;
    end
    if (s_q.an_cnt1 == ANALOG_CNT_W'(ANALOG_CYCLES - 1)) begin
      s_d.an_lvl[1] = sync2_q[5];
      s_d.an_cnt1 = '0;
    end
    if (s_q.an_cnt2 == ANALOG_CNT_W'(ANALOG_CYCLES - 1)) begin
      s_d.an_lvl[2] = sync2_q[6];
      s_d.an_cnt2 = '0;
    end
    // edge detection on filtered levels
    s_d.level = filt_lvl;
    for (int i = 0; i < NUM_PINS; i++) begin
      s_d.edge_out[i] = !s_q.mute[i] &&
        is_valid_edge(field_of(sel_all, i), s_q.level[i], filt_lvl[i]);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.edge_sel_a <= RESET_VAL;
      s_q.edge_sel_b <= RESET_VAL;
      s_q.filt_clk_sel <= RESET_VAL;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rresp = s_q.rresp;
  assign s_axi_rdata = s_q.rdata;
  assign edge_detected = s_q.edge_out;

endmodule
